// [hdl/sgs_pkg.sv]
// sgs_pkg: constants and types for the servo gain switch parameter block.
// assumes a 100 MHz aclk and AXI4-Lite register access with 32-bit data.
package sgs_pkg;

	// =========================================================
	// widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 7;
	localparam int VAL_W = 16;
	localparam int GAIN_N = 7;
	localparam int REG_N = 16;

	// =========================================================
	// register indices, byte address is index times four
	localparam int REG_CTRL = 0;
	localparam int REG_TC = 1;
	localparam int REG_BASE0 = 2;
	localparam int REG_POST0 = 9;
	localparam int REG_STATUS = 16;
	localparam int IDX_MAX = 31;

	// =========================================================
	// gain set members, order shared by base and post-switch banks
	localparam int G_POS = 0;
	localparam int G_SPD = 1;
	localparam int G_INT = 2;
	localparam int G_VFREQ = 3;
	localparam int G_RFREQ = 4;
	localparam int G_VDAMP = 5;
	localparam int G_RDAMP = 6;

	// =========================================================
	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_TUNE_LSB = 4;
	localparam int CTRL_SEL_LSB = 8;
	localparam int CTRL_CMD_BIT = 12;
	localparam int FIELD_W = 4;
	localparam logic [VAL_W-1:0] CTRL_MASK = 16'h1FFF;

	// =========================================================
	// mode values
	localparam logic [3:0] MODE_MANUAL = 4'h3;
	localparam logic [3:0] TUNE_MANUAL = 4'h2;
	localparam logic [3:0] SEL_CMD_INPUT = 4'h1;

	// =========================================================
	// value units: 0.1 rad/s, 1 rad/s, 0.1 ms, 0.1 Hz, 0.01
	localparam logic [VAL_W-1:0] POS_MIN = 16'h000A;
	localparam logic [VAL_W-1:0] SPD_MIN = 16'h0014;
	localparam logic [VAL_W-1:0] INT_MIN = 16'h0001;
	localparam logic [VAL_W-1:0] FREQ_MIN = 16'h0001;
	localparam logic [VAL_W-1:0] POS_MAX = 16'h4E20;
	localparam logic [VAL_W-1:0] SPD_MAX = 16'hFFFF;
	localparam logic [VAL_W-1:0] INT_MAX = 16'hC350;
	localparam logic [VAL_W-1:0] FREQ_MAX = 16'h0BB8;
	localparam logic [VAL_W-1:0] DAMP_MAX = 16'h001E;
	localparam logic [VAL_W-1:0] TC_MAX = 16'h0064;

	// =========================================================
	// reset values
	localparam logic [VAL_W-1:0] TC_RESET = 16'h0001;
	localparam logic [VAL_W-1:0] VAL_RESET = 16'h0000;

	// =========================================================
	// timing: time constant unit is 1 ms, clock period 10 ns
	localparam int TC_UNIT_NS = 1000000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYC_PER_MS = TC_UNIT_NS / CLK_PERIOD_NS;
	localparam int W_BITS = 8;
	localparam logic [W_BITS:0] W_FULL = 9'h100;
	localparam int TICK_W = 24;

	// =========================================================
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// =========================================================
	// types
	typedef logic [GAIN_N-1:0][VAL_W-1:0] sgs_gain_set_t;

	typedef enum logic [2:0] {
		PH_BASE = 3'b001,
		PH_RAMP = 3'b010,
		PH_POST = 3'b100
	} sgs_phase_t;

endpackage : sgs_pkg

// [hdl/sgs_gain_switch.sv]
// sgs_gain_switch: picks and blends the gain set handed to the servo loops.
// assumes an AXI4-Lite master on aclk and an asynchronous switch input pin.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module sgs_gain_switch #(
	parameter int CLK_PER_MS = sgs_pkg::CYC_PER_MS
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [sgs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [sgs_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [sgs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [sgs_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// gain switching pin, asynchronous
	input wire logic gain_switch_input,
	// gain set to the control loops
	output sgs_pkg::sgs_gain_set_t eff_gains,
	output logic switch_active
);
	import sgs_pkg::*;

	typedef struct packed {
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [DATA_W-1:0] rdata;
		logic [REG_N-1:0][VAL_W-1:0] regs;
		logic sync1;
		logic sync2;
		logic active;
		sgs_phase_t phase;
		logic [W_BITS:0] weight;
		logic [TICK_W-1:0] tick;
		sgs_gain_set_t eff;
	} sgs_state_t;

	sgs_state_t q;
	sgs_state_t d;

	// =========================================================
	// helpers
	function automatic logic [VAL_W-1:0] clamp_val(
		input int idx,
		input logic [VAL_W-1:0] v
	);
		logic [VAL_W-1:0] mx;
		mx = SPD_MAX;
		if (idx == REG_CTRL)
			return v & CTRL_MASK;
		if (idx == REG_TC)
			mx = TC_MAX;
		else if (idx >= REG_BASE0) begin
			case ((idx - REG_BASE0) % GAIN_N)
				G_POS: mx = POS_MAX;
				G_SPD: mx = SPD_MAX;
				G_INT: mx = INT_MAX;
				G_VFREQ: mx = FREQ_MAX;
				G_RFREQ: mx = FREQ_MAX;
				default: mx = DAMP_MAX;
			endcase
		end
		return (v > mx) ? mx : v;
	endfunction : clamp_val

	function automatic logic [VAL_W-1:0] merge(
		input logic [VAL_W-1:0] old,
		input logic [DATA_W-1:0] data,
		input logic [3:0] strb
	);
		logic [VAL_W-1:0] r;
		r = old;
		if (strb[0])
			r[7:0] = data[7:0];
		if (strb[1])
			r[15:8] = data[15:8];
		return r;
	endfunction : merge

	// blend base toward post by weight out of W_FULL
	function automatic logic [VAL_W-1:0] blend(
		input logic [VAL_W-1:0] a,
		input logic [VAL_W-1:0] b,
		input logic [W_BITS:0] w
	);
		logic [VAL_W+W_BITS+1:0] s;
		s = {2'h0, a} * {{VAL_W{1'b0}}, W_FULL - w}
			+ {2'h0, b} * {{VAL_W{1'b0}}, w};
		return s[VAL_W+W_BITS-1:W_BITS];
	endfunction : blend

	// post value unless disabled or below its floor
	function automatic logic [VAL_W-1:0] pick(
		input logic en,
		input logic [VAL_W-1:0] pval,
		input logic [VAL_W-1:0] bval,
		input logic [VAL_W-1:0] lim
	);
		return (en && pval >= lim) ? pval : bval;
	endfunction : pick

	// word index from a byte address, shared by both directions
	function automatic int reg_index(input logic [ADDR_W-1:0] a);
		return int'(a[ADDR_W-1:2]);
	endfunction : reg_index

	// =========================================================
	// derived control
	logic [3:0] mode_sel;
	logic [3:0] tune_sel;
	logic [3:0] sw_sel;
	logic cmd_bit;
	logic gain_en;
	logic vib_en;
	logic [31:0] step_lim;
	sgs_gain_set_t base_set;
	sgs_gain_set_t post_set;

	always_comb begin
		mode_sel = q.regs[REG_CTRL][CTRL_MODE_LSB +: FIELD_W];
		tune_sel = q.regs[REG_CTRL][CTRL_TUNE_LSB +: FIELD_W];
		sw_sel = q.regs[REG_CTRL][CTRL_SEL_LSB +: FIELD_W];
		cmd_bit = q.regs[REG_CTRL][CTRL_CMD_BIT];
		gain_en = (mode_sel == MODE_MANUAL);
		vib_en = gain_en && (tune_sel == TUNE_MANUAL)
			&& (sw_sel == SEL_CMD_INPUT);
		step_lim = (32'(q.regs[REG_TC]) * 32'(CLK_PER_MS)) >> W_BITS;
		for (int i = 0; i < GAIN_N; i++) begin
			base_set[i] = q.regs[REG_BASE0 + i];
			post_set[i] = q.regs[REG_POST0 + i];
		end
		post_set[G_POS] = pick(gain_en, post_set[G_POS],
			base_set[G_POS], POS_MIN);
		post_set[G_SPD] = pick(gain_en, post_set[G_SPD],
			base_set[G_SPD], SPD_MIN);
		post_set[G_INT] = pick(gain_en, post_set[G_INT],
			base_set[G_INT], INT_MIN);
		post_set[G_VFREQ] = pick(vib_en, post_set[G_VFREQ],
			base_set[G_VFREQ], FREQ_MIN);
		post_set[G_RFREQ] = pick(vib_en, post_set[G_RFREQ],
			base_set[G_RFREQ], FREQ_MIN);
		if (!vib_en) begin
			post_set[G_VDAMP] = base_set[G_VDAMP];
			post_set[G_RDAMP] = base_set[G_RDAMP];
		end
	end

	// =========================================================
	// next state
	logic [W_BITS:0] w_tgt;
	int widx;
	int ridx;

	always_comb begin
		d = q;
		w_tgt = '0;
		widx = 0;
		ridx = 0;

		// pin synchroniser and activation
		d.sync1 = gain_switch_input;
		d.sync2 = q.sync1;
		d.active = (sw_sel == SEL_CMD_INPUT) && (cmd_bit || q.sync2);

		// weight ramp paced by the time constant
		w_tgt = q.active ? W_FULL : '0;
		d.tick = '0;
		if (q.weight != w_tgt) begin
			if (step_lim == 0)
				d.weight = w_tgt;
			else if (32'(q.tick) >= step_lim - 1) begin
				if (q.weight < w_tgt)
					d.weight = q.weight + 1'b1;
				else
					d.weight = q.weight - 1'b1;
			end else
				d.tick = q.tick + 1'b1;
		end
		if (q.weight == '0)
			d.phase = PH_BASE;
		else if (q.weight == W_FULL)
			d.phase = PH_POST;
		else
			d.phase = PH_RAMP;

		// zero weight gives exactly the base set
		for (int i = 0; i < GAIN_N; i++)
			d.eff[i] = blend(base_set[i], post_set[i], q.weight);

		// axi write channels, taken in either order
		if (s_axi_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (d.aw_have && d.w_have && !q.bvalid) begin
			widx = reg_index(d.aw_addr);
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = (widx > REG_STATUS) ? RESP_SLVERR : RESP_OKAY;
			if (widx < REG_N)
				d.regs[widx] = clamp_val(widx,
					merge(q.regs[widx], d.wdata, d.wstrb));
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;

		// axi read
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (s_axi_arvalid && q.arready) begin
			ridx = reg_index(s_axi_araddr);
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = '0;
			if (ridx < REG_N)
				d.rdata = {16'h0000, q.regs[ridx]};
			else if (ridx == REG_STATUS)
				d.rdata = {16'h0000, 1'b0, q.weight, q.phase,
					vib_en, gain_en, q.active};
			else
				d.rresp = RESP_SLVERR;
		end
		d.arready = !d.rvalid;
	end

	// =========================================================
	// reset value of the whole state
	function automatic sgs_state_t reset_state();
		sgs_state_t r;
		r = '0;
		r.phase = PH_BASE;
		for (int i = 0; i < REG_N; i++)
			r.regs[i] = VAL_RESET;
		r.regs[REG_TC] = TC_RESET;
		return r;
	endfunction : reset_state

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= reset_state();
		else
			q <= d;
	end

	// =========================================================
	// outputs
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;
	assign eff_gains = q.eff;
	assign switch_active = q.active;

endmodule : sgs_gain_switch

// [test/sgs_pin_model.sv]
// sgs_pin_model: stand-in for the gain switching input device.
// assumes the bench asks for a change only with the motor at rest.
`timescale 1ns/100ps
module sgs_pin_model (
	// request and motor state
	input wire logic req,
	input wire logic motor_stopped,
	// pin to the block
	output logic pin
);
	initial pin = 1'b0;
	// moves off the clock grid, only at rest
	always @(req) begin
		if (motor_stopped)
			#3.3 pin = req;
	end
endmodule : sgs_pin_model

// [test/sgs_gain_switch_props.sv]
// sgs_gain_switch_props: bus and reset checks on the top ports.
// assumes one clock domain and a synchronous low reset.
`timescale 1ns/100ps
module sgs_gain_switch_props (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// loop side
	input wire sgs_pkg::sgs_gain_set_t eff_gains,
	input wire logic switch_active
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// =========================================================
	// sequences
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_bdone;
		!s_axi_bvalid ##1 (s_axi_awready && s_axi_wready);
	endsequence
	// =========================================================
	// properties
	property p_rst;
		$rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !switch_active
			&& eff_gains == '0;
	endproperty
	property p_wtake;
		s_wtake |=> s_axi_bvalid;
	endproperty
	property p_bdone;
		s_axi_bvalid && s_axi_bready |=> s_bdone;
	endproperty
	property p_rtake;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_rdone;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
	endproperty
	property p_arblk;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_awblk;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_upper;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	a_wtake: assert property (p_wtake) else $error("no write response");
	a_bdone: assert property (p_bdone) else $error("write did not close");
	a_rtake: assert property (p_rtake) else $error("no read data");
	a_rdone: assert property (p_rdone) else $error("read did not close");
	a_arblk: assert property (p_arblk) else $error("read taken while busy");
	a_awblk: assert property (p_awblk) else $error("write taken while busy");
	a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule : sgs_gain_switch_props
bind sgs_gain_switch sgs_gain_switch_props sgs_gain_switch_props_i (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.eff_gains, .switch_active);

// [test/tb.sv]
// tb: self-checking bench for the gain switch block.
// assumes sgs_pkg and the pin model are compiled first.
`timescale 1ns/100ps
module tb;
	import sgs_pkg::*;
	logic aclk = 0, aresetn = 0, pin_req = 0, probe = 0, pin;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, switch_active;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	sgs_gain_set_t eff_gains, base, post;
	logic [1:0] qb[$];
	logic [33:0] qr[$];
	logic [112:0] qg[$];
	logic act;
	logic [15:0] lf = 16'h9BC9;
	int num_errors = 0, check_count = 0;
	int ci[6] = '{9, 10, 11, 12, 15, 1};
	logic [15:0] cm[6] = '{16'h4E20, 16'hFFFF, 16'hC350, 16'h0BB8, 16'h001E,
		16'h0064};
	logic [15:0] cc[5] = '{16'h1123, 16'h0123, 16'h0023, 16'h1113, 16'h1122};
	logic [1:0] ce[5] = '{2'h3, 2'h3, 2'h0, 2'h2, 2'h0};
	logic cp[5] = '{0, 1, 1, 0, 0};

	sgs_gain_switch #(.CLK_PER_MS(256)) sgs_gain_switch_i (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .gain_switch_input(pin), .eff_gains, .switch_active);
	sgs_pin_model sgs_pin_model_i (.req(pin_req), .motor_stopped(1'b1),
		.pin(pin));

	always #5 aclk = ~aclk;

	// =========================================================
	// result checking
	task summarize;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic tally(input logic [112:0] got, input logic [112:0] e);
		check_count++;
		if (got !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, e);
		end
	endtask : tally
	task automatic compare_b(input logic [1:0] got);
		logic [1:0] e;
		e = (qb.size() > 0) ? qb.pop_front() : 'x;
		tally(113'(got), 113'(e));
	endtask : compare_b
	task automatic compare_r(input logic [33:0] got);
		logic [33:0] e;
		e = (qr.size() > 0) ? qr.pop_front() : 'x;
		tally(113'(got), 113'(e));
	endtask : compare_r
	task automatic compare_g(input logic [112:0] got);
		logic [112:0] e;
		e = (qg.size() > 0) ? qg.pop_front() : 'x;
		tally(got, e);
	endtask : compare_g
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			compare_r({s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			compare_b(s_axi_bresp);
		if (probe)
			compare_g({switch_active, eff_gains});
	end

	// =========================================================
	// bus tasks
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic wr(input int idx, input logic [15:0] v,
		input logic [1:0] er = RESP_OKAY);
		int n;
		qb.push_back(er);
		s_axi_awaddr <= 7'(idx * 4);
		s_axi_wdata <= {16'h0000, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 0;
		if (n == 50) begin num_errors++; summarize(); end
		@(posedge aclk);
	endtask : wr
	task automatic rd(input int idx, input logic [33:0] e);
		int n;
		qr.push_back(e);
		s_axi_araddr <= 7'(idx * 4);
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 0;
		if (n == 50) begin num_errors++; summarize(); end
		@(posedge aclk);
	endtask : rd
	task automatic expect_gains(input logic a, input logic g, input logic v);
		sgs_gain_set_t e;
		e = base;
		if (g && post[G_POS] >= POS_MIN) e[G_POS] = post[G_POS];
		if (g && post[G_SPD] >= SPD_MIN) e[G_SPD] = post[G_SPD];
		if (g && post[G_INT] >= INT_MIN) e[G_INT] = post[G_INT];
		if (v && post[G_VFREQ] >= FREQ_MIN) e[G_VFREQ] = post[G_VFREQ];
		if (v && post[G_RFREQ] >= FREQ_MIN) e[G_RFREQ] = post[G_RFREQ];
		if (v) e[G_VDAMP] = post[G_VDAMP];
		if (v) e[G_RDAMP] = post[G_RDAMP];
		qg.push_back({a, e});
		probe <= 1;
		@(posedge aclk);
		probe <= 0;
	endtask : expect_gains

	// =========================================================
	// main sequence
	initial begin
		post = {16'h0004, 16'h0003, 16'h0000, 16'h0001, 16'h0000, 16'h0013,
			16'h000A};
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(1, 34'h1);
		rd(9, 34'h0);
		rd(10, 34'h0);
		rd(20, {RESP_SLVERR, 32'h0});
		wr(20, 16'h1234, RESP_SLVERR);
		for (int i = 0; i < 6; i++) begin
			wr(ci[i], 16'hFFFF);
			rd(ci[i], 34'(cm[i]));
		end
		s_axi_wstrb <= 4'h1;
		wr(REG_TC, 16'hFF05);
		rd(REG_TC, 34'h5);
		s_axi_wstrb <= 4'hF;
		wr(1, 16'h0000);
		for (int i = 0; i < GAIN_N; i++) begin
			lf = lfsr(lf);
			base[i] = (i < 5) ? {5'h00, lf[10:0]} : {12'h000, lf[3:0]};
			wr(REG_BASE0 + i, base[i]);
			wr(REG_POST0 + i, post[i]);
		end
		for (int k = 0; k < 5; k++) begin
			wr(REG_CTRL, cc[k]);
			pin_req <= cp[k];
			repeat (8) @(posedge aclk);
			act = (cc[k][CTRL_SEL_LSB +: FIELD_W] == SEL_CMD_INPUT)
				&& (cc[k][CTRL_CMD_BIT] || cp[k]);
			expect_gains(act, ce[k][1], ce[k][0]);
		end
		wr(REG_CTRL, 16'h0023);
		wr(REG_TC, 16'h0001);
		wr(REG_CTRL, 16'h1123);
		repeat (270) @(posedge aclk);
		expect_gains(1, 1, 1);
		rd(REG_STATUS, 34'h4027);
		summarize();
	end
	initial begin
		repeat (100000) @(posedge aclk);
		num_errors++;
		summarize();
	end
endmodule : tb
